/* File: src/pol_port_latch.sv */
// Port output latches for two byte-wide ports with APB access
`timescale 1ns/1ps
`default_nettype none

module pol_port_latch import pol_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [POL_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        p0_pin_in,
	output logic      [7:0]        p0_pin_out,
	output logic      [7:0]        p0_pin_oe,
	input  wire logic [7:0]        p1_pin_in,
	output logic      [7:0]        p1_pin_out,
	output logic      [7:0]        p1_pin_oe,
	input  wire pol_emif_t         emif_claim,
	input  wire pol_emif_t         emif_drive
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [POL_AW-1:0] a,
		input logic [11:0] off);
		hit = (a == off);
	endfunction : hit

	logic        setup_w;
	logic        access_w;
	logic        wr_w;
	logic        mapped_w;

	assign setup_w  = psel & ~penable;
	assign access_w = psel & penable;
	assign wr_w     = access_w & pwrite & pstrb[0];
	assign mapped_w = hit(paddr, POL_P0_LATCH_OFF) | hit(paddr, POL_P1_LATCH_OFF)
		| hit(paddr, POL_P0_MODE_OFF) | hit(paddr, POL_P1_MODE_OFF);

	// Zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// Pin input sampling
	// ----------------------------------------------------------------
	logic [7:0]  p0_sync;
	logic [7:0]  p1_sync;

	pol_sync2 #(.W(8)) u_sync_p0
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (p0_pin_in),
		.q       (p0_sync)
	);

	pol_sync2 #(.W(8)) u_sync_p1
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (p1_pin_in),
		.q       (p1_sync)
	);

	// ----------------------------------------------------------------
	// Output latches
	// ----------------------------------------------------------------
	logic [7:0]  p0_latch_q;
	logic [7:0]  p1_latch_q;
	logic [7:0]  p0_mode_q;
	logic [7:0]  p1_mode_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p0_latch_q <= POL_LATCH_RST;
		else if (wr_w && hit(paddr, POL_P0_LATCH_OFF))
			p0_latch_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p1_latch_q <= POL_LATCH_RST;
		else if (wr_w && hit(paddr, POL_P1_LATCH_OFF))
			p1_latch_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p0_mode_q <= POL_MODE_RST;
		else if (wr_w && hit(paddr, POL_P0_MODE_OFF))
			p0_mode_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			p1_mode_q <= POL_MODE_RST;
		else if (wr_w && hit(paddr, POL_P1_MODE_OFF))
			p1_mode_q <= pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup_w)
		begin
			pslverr <= ~mapped_w;
			if (pwrite || !mapped_w)
				prdata <= 32'h0000_0000;
			else if (hit(paddr, POL_P0_LATCH_OFF))
				prdata <= {24'h00_0000, p0_sync};
			else if (hit(paddr, POL_P1_LATCH_OFF))
				prdata <= {24'h00_0000, p1_sync};
			else if (hit(paddr, POL_P0_MODE_OFF))
				prdata <= {24'h00_0000, p0_mode_q};
			else
				prdata <= {24'h00_0000, p1_mode_q};
		end
	end

	// ----------------------------------------------------------------
	// Memory strobe takeover on port 0
	// ----------------------------------------------------------------
	logic [7:0]  p0_level;
	logic [7:0]  p0_mode_eff;

	always_comb
	begin
		p0_level    = p0_latch_q;
		p0_mode_eff = p0_mode_q;
		// Claimed strobes are driven actively both ways
		if (emif_claim.wr_n)
		begin
			p0_level[POL_WR_BIT]    = emif_drive.wr_n;
			p0_mode_eff[POL_WR_BIT] = 1'b1;
		end
		if (emif_claim.rd_n)
		begin
			p0_level[POL_RD_BIT]    = emif_drive.rd_n;
			p0_mode_eff[POL_RD_BIT] = 1'b1;
		end
		if (emif_claim.ale)
		begin
			p0_level[POL_ALE_BIT]    = emif_drive.ale;
			p0_mode_eff[POL_ALE_BIT] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	pol_pin_drv_t p0_drv;
	pol_pin_drv_t p1_drv;

	pol_pin_drive u_drv_p0
	(
		.pclk    (pclk),
		.presetn (presetn),
		.level   (p0_level),
		.mode    (p0_mode_eff),
		.drv     (p0_drv)
	);

	pol_pin_drive u_drv_p1
	(
		.pclk    (pclk),
		.presetn (presetn),
		.level   (p1_latch_q),
		.mode    (p1_mode_q),
		.drv     (p1_drv)
	);

	assign p0_pin_out = p0_drv.out;
	assign p0_pin_oe  = p0_drv.oe;
	assign p1_pin_out = p1_drv.out;
	assign p1_pin_oe  = p1_drv.oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic first_done_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_done_q <= 1'b0;
		else
			first_done_q <= 1'b1;
	end

	a_p1_write_pin: assert property (@(posedge pclk) disable iff (!presetn)
		wr_w && hit(paddr, POL_P1_LATCH_OFF)
		|=> ##1 p1_pin_out == $past(pwdata[7:0], 2))
		else $error("port one pin level does not follow latch write");

	a_p0_write_pin: assert property (@(posedge pclk) disable iff (!presetn)
		wr_w && hit(paddr, POL_P0_LATCH_OFF)
		|=> ##1 p0_pin_out[4:0] == $past(pwdata[4:0], 2))
		else $error("port zero pin level does not follow latch write");

	a_open_high_bits: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (p1_pin_oe & $past(p1_latch_q & ~p1_mode_q)) == 8'h00)
		else $error("open-drain high bit is being driven");

	a_push_high_bits: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (p1_pin_oe & $past(p1_latch_q)) == $past(p1_latch_q & p1_mode_q))
		else $error("push-pull high bit is not driven");

	a_low_driven: assert property (@(posedge pclk) disable iff (!presetn)
		first_done_q |-> (p1_pin_oe | p1_pin_out) == 8'hff)
		else $error("low pin level left undriven");

	a_read_pins_p0: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w && !pwrite && hit(paddr, POL_P0_LATCH_OFF)
		|=> prdata == {24'h00_0000, $past(p0_sync)})
		else $error("port zero read is not the pin level");

	a_read_pins_p1: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w && !pwrite && hit(paddr, POL_P1_LATCH_OFF) && first_done_q
		&& $past(first_done_q) && $past(first_done_q, 2)
		|=> prdata[7:0] == $past(p1_pin_in, 3))
		else $error("port one read bit does not encode the pin");

	a_wr_strobe_own: assert property (@(posedge pclk) disable iff (!presetn)
		emif_claim.wr_n
		|=> p0_pin_out[POL_WR_BIT] == $past(emif_drive.wr_n) && p0_pin_oe[POL_WR_BIT])
		else $error("write strobe pin not taken over");

	a_rd_ale_own: assert property (@(posedge pclk) disable iff (!presetn)
		emif_claim.rd_n && emif_claim.ale
		|=> p0_pin_out[POL_RD_BIT] == $past(emif_drive.rd_n)
		&& p0_pin_out[POL_ALE_BIT] == $past(emif_drive.ale)
		&& p0_pin_oe[POL_RD_BIT] && p0_pin_oe[POL_ALE_BIT])
		else $error("read or latch strobe pin not taken over");

	a_rd_strobe_own: assert property (@(posedge pclk) disable iff (!presetn)
		emif_claim.rd_n
		|=> p0_pin_out[POL_RD_BIT] == $past(emif_drive.rd_n) && p0_pin_oe[POL_RD_BIT])
		else $error("read strobe pin not taken over");

	a_ale_strobe_own: assert property (@(posedge pclk) disable iff (!presetn)
		emif_claim.ale
		|=> p0_pin_out[POL_ALE_BIT] == $past(emif_drive.ale) && p0_pin_oe[POL_ALE_BIT])
		else $error("address latch strobe pin not taken over");

	a_strobe_release: assert property (@(posedge pclk) disable iff (!presetn)
		!emif_claim.wr_n && !emif_claim.rd_n && !emif_claim.ale
		|=> p0_pin_out[7:5] == $past(p0_latch_q[7:5]))
		else $error("released strobe pins do not follow the latch");

	a_p0_open_bits: assert property (@(posedge pclk) disable iff (!presetn)
		!emif_claim.wr_n && !emif_claim.rd_n && !emif_claim.ale
		|=> (p0_pin_oe & $past(p0_latch_q & ~p0_mode_q)) == 8'h00)
		else $error("port zero open-drain high bit is being driven");

	a_reset_latch: assert property (@(posedge pclk) disable iff (!presetn)
		!first_done_q |-> p0_latch_q == 8'hff && p1_latch_q == 8'hff
		&& p1_pin_out == 8'hff && p1_pin_oe == 8'h00)
		else $error("latches not all ones after reset");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w && !mapped_w |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not flagged");

	a_no_strobe_hold: assert property (@(posedge pclk) disable iff (!presetn)
		access_w && pwrite && !pstrb[0]
		|=> $stable(p0_latch_q) && $stable(p1_latch_q))
		else $error("latch changed on a write without its byte strobe");

	a_mode_readback: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w && !pwrite && hit(paddr, POL_P1_MODE_OFF)
		|=> prdata == {24'h00_0000, $past(p1_mode_q)})
		else $error("drive mode read does not return the stored bits");

	a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read data bits are not zero");

	a_write_no_data: assert property (@(posedge pclk) disable iff (!presetn)
		setup_w && pwrite |=> prdata == 32'h0000_0000)
		else $error("write cycle left read data on the bus");

endmodule : pol_port_latch

`default_nettype wire

/* File: inc/pol_pkg.sv */
// Constants and types for the port output latch block
//
// What this block does
// - Software writes set each latch bit; the bit's level drives its pin.
// - Latch 1 with drive mode 0 leaves the pin open; mode 1 drives high.
// - Reading a port returns sampled pin levels, not the latch contents.
// - Each read bit is 0 for a low pin and 1 for a high pin.
// - Port-0 bits 7, 6, 5 carry memory write, read, latch strobes when claimed.
package pol_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          POL_AW           = 12;
	localparam logic [11:0] POL_P0_LATCH_OFF = 12'h000;
	localparam logic [11:0] POL_P1_LATCH_OFF = 12'h004;
	localparam logic [11:0] POL_P0_MODE_OFF  = 12'h008;
	localparam logic [11:0] POL_P1_MODE_OFF  = 12'h00c;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  POL_LATCH_RST    = 8'hff;
	localparam logic [7:0]  POL_MODE_RST     = 8'h00;
	localparam logic [7:0]  POL_OUT_RST      = 8'hff;
	localparam logic [7:0]  POL_OE_RST       = 8'h00;

	// ----------------------------------------------------------------
	// Port-0 pins shared with the memory interface
	// ----------------------------------------------------------------
	localparam int          POL_WR_BIT       = 7;
	localparam int          POL_RD_BIT       = 6;
	localparam int          POL_ALE_BIT      = 5;
	localparam int          POL_SYNC_STAGES  = 2;

	typedef struct packed {
		logic wr_n;
		logic rd_n;
		logic ale;
	} pol_emif_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pol_pin_drv_t;

endpackage : pol_pkg

/* File: src/pol_sync2.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pol_sync2 import pol_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : pol_sync2

`default_nettype wire

/* File: src/pol_pin_drive.sv */
// Registered pin driver: level plus drive mode to output and enable
`timescale 1ns/1ps
`default_nettype none

module pol_pin_drive import pol_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [7:0]   level,
	input  wire logic [7:0]   mode,
	output var pol_pin_drv_t  drv
);

	// A high level is driven only in push-pull mode, else left open
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drv.out <= POL_OUT_RST;
			drv.oe  <= POL_OE_RST;
		end
		else
		begin
			drv.out <= level;
			drv.oe  <= ~level | mode;
		end
	end

endmodule : pol_pin_drive

`default_nettype wire

/* File: verification/port_output_latch_test.sv */
// Self-checking testbench for the port output latch block
`timescale 1ns/1ps
`default_nettype none

module port_output_latch_test import pol_pkg::*;;
	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  p0_pin_in, p0_pin_out, p0_pin_oe, p0_ext;
	logic [7:0]  p1_pin_in, p1_pin_out, p1_pin_oe, p1_ext;
	pol_emif_t   emif_claim;
	pol_emif_t   emif_drive;
	logic [7:0]  lat [2];
	logic [7:0]  mode [2];
	logic [7:0]  cm, dm;
	logic [31:0] rd;
	logic        err;
	int          errors, checks_done, seed, cycles, i, pt;

	// ----------------------------------------------------------------
	// Pin wires: driven level where enabled, else the outside level
	// ----------------------------------------------------------------
	assign p0_pin_in = (p0_pin_oe & p0_pin_out) | (~p0_pin_oe & p0_ext);
	assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & p1_ext);

	pol_port_latch pol_port_latch_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .p0_pin_in(p0_pin_in),
		.p0_pin_out(p0_pin_out), .p0_pin_oe(p0_pin_oe), .p1_pin_in(p1_pin_in),
		.p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe), .emif_claim(emif_claim),
		.emif_drive(emif_drive));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask : check

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected pin level seen by a read: latch where driven, outside level where open
	function automatic logic [31:0] exp_pin(input int p);
		logic [7:0] oe;
		oe = ~lat[p] | mode[p];
		return {24'h0, (oe & lat[p]) | (~oe & (p == 0 ? p0_ext : p1_ext))};
	endfunction : exp_pin

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata, pstrb} = '0;
		{p0_ext, p1_ext} = 16'hffff;
		emif_claim = '0;
		emif_drive = '0;
		{errors, checks_done} = '0;
		seed = 39;
		lat = '{8'hff, 8'hff};
		mode = '{8'h00, 8'h00};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("p0 out", {p0_pin_oe, p0_pin_out}, 16'h00ff);
		check("p1 out", {p1_pin_oe, p1_pin_out}, 16'h00ff);
		apb(1'b0, POL_P1_MODE_OFF, 32'h0, 4'h0);
		check("mode rst", rd, 32'h0);
		$display("test reset done");
		for (i = 0; i < 8; i++)
		begin
			p0_ext <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			p1_ext <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
			repeat (4) @(posedge pclk);
			apb(1'b0, POL_P0_LATCH_OFF, 32'h0, 4'h0);
			check("p0 read", rd, exp_pin(0));
			apb(1'b0, POL_P1_LATCH_OFF, 32'h0, 4'h0);
			check("p1 read", rd, exp_pin(1));
		end
		$display("test pin read done");
		for (i = 0; i < 16; i++)
		begin
			pt = i % 2;
			lat[pt] = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : 8'($random(seed));
			mode[pt] = (i < 4) ? 8'h0f : 8'($random(seed));
			apb(1'b1, 12'(8 + 4 * pt), {24'h5a5a5a, mode[pt]}, 4'hf);
			apb(1'b1, 12'(4 * pt), {24'ha5a5a5, lat[pt]}, 4'h1);
			p0_ext <= 8'($random(seed));
			p1_ext <= 8'($random(seed));
			repeat (2) @(posedge pclk);
			check("latch out", pt ? p1_pin_out : p0_pin_out, lat[pt]);
			check("latch oe", pt ? p1_pin_oe : p0_pin_oe, 8'(~lat[pt] | mode[pt]));
			repeat (3) @(posedge pclk);
			apb(1'b0, 12'(4 * pt), 32'h0, 4'h0);
			check("pin read", rd, exp_pin(pt));
			apb(1'b0, 12'(8 + 4 * pt), 32'h0, 4'h0);
			check("mode read", rd, {24'h0, mode[pt]});
		end
		$display("test latch write done");
		apb(1'b1, POL_P1_LATCH_OFF, ~lat[1], 4'he);
		repeat (2) @(posedge pclk);
		check("strobe off", p1_pin_out, lat[1]);
		apb(1'b0, 12'h010, 32'h0, 4'h0);
		check("unmapped err", err, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, 12'h010, 32'h0, 4'hf);
		check("unmapped write err", err, 32'h1);
		$display("test refusal done");
		for (i = 0; i < 8; i++)
		begin
			emif_claim <= pol_emif_t'(3'(i));
			emif_drive <= pol_emif_t'(3'($random(seed)));
			repeat (2) @(posedge pclk);
			cm = {emif_claim, 5'h0};
			dm = {emif_drive, 5'h0};
			check("emif out", p0_pin_out, (lat[0] & ~cm) | (dm & cm));
			check("emif oe", p0_pin_oe, 8'(((~lat[0] | mode[0]) & ~cm) | cm));
		end
		emif_claim <= '0;
		repeat (2) @(posedge pclk);
		check("emif off", {p0_pin_oe, p0_pin_out}, {~lat[0] | mode[0], lat[0]});
		$display("test memory strobes done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("p0 again", {p0_pin_oe, p0_pin_out}, 16'h00ff);
		check("p1 again", {p1_pin_oe, p1_pin_out}, 16'h00ff);
		apb(1'b0, POL_P0_MODE_OFF, 32'h0, 4'h0);
		check("mode again", rd, 32'h0);
		$display("test second reset done");
		give_verdict();
	end
endmodule : port_output_latch_test

`default_nettype wire
